// >>> rtl/sbst_pkg.sv
/*
 Shared constants and types of the SRAM boundary-scan test port.
 Assumes a single 40 MHz system clock; the test clock is only sampled.
*/
package sbst_pkg;
   localparam int IR_LEN = 3;
   localparam int ID_LEN = 32;
   localparam int BSR_LEN = 109;
   localparam int BSR_TRI_BIT = 108;

   localparam logic [2:0] IR_EXTEST = 3'h0;
   localparam logic [2:0] IR_IDCODE = 3'h1;
   localparam logic [2:0] IR_SAMPLEZ = 3'h2;
   localparam logic [2:0] IR_SAMPLE = 3'h4;
   localparam logic [2:0] IR_BYPASS = 3'h7;
   localparam logic [2:0] IR_CAPT_PAT = 3'h1;

   localparam int ID_REV_HI = 31;
   localparam int ID_REV_LO = 29;
   localparam int ID_PART_HI = 28;
   localparam int ID_PART_LO = 12;
   localparam int ID_MAKER_HI = 11;
   localparam int ID_MAKER_LO = 1;
   localparam int ID_PRESENT_BIT = 0;

   localparam int AXI_AW = 8;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IDWORD = 8'h08;
   localparam int CTRL_TAP_RST_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [15:0] {
      ST_TLR = 16'h0001,
      ST_RTI = 16'h0002,
      ST_SELDR = 16'h0004,
      ST_CAPDR = 16'h0008,
      ST_SHDR = 16'h0010,
      ST_EX1DR = 16'h0020,
      ST_PDR = 16'h0040,
      ST_EX2DR = 16'h0080,
      ST_UPDR = 16'h0100,
      ST_SELIR = 16'h0200,
      ST_CAPIR = 16'h0400,
      ST_SHIR = 16'h0800,
      ST_EX1IR = 16'h1000,
      ST_PIR = 16'h2000,
      ST_EX2IR = 16'h4000,
      ST_UPIR = 16'h8000
   } sbst_state_t;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } sbst_tap_in_t;
endpackage

// >>> rtl/sbst_sync.sv
/*
 Two-flop synchroniser for a bundle of independent levels.
 Assumes each bit is a slow level relative to mclk.
*/
`timescale 1ns/1ps
module sbst_sync #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q_r
);
   logic [W-1:0] meta_r;

   if (W < 1)
   begin : g_chk
      $error("sbst_sync: width must be positive");
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         meta_r <= '0;
         q_r <= '0;
      end
      else
      begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end
endmodule // sbst_sync

// >>> rtl/sbst_tap_fsm.sv
/*
 Sixteen-state test access port controller.
 Assumes step is a one-cycle pulse per test clock rise and tms is synchronised.
*/
`timescale 1ns/1ps
module sbst_tap_fsm (
   input wire logic mclk,
   input wire logic srst,
   input wire logic step,
   input wire logic tms,
   input wire logic force_tlr,
   output sbst_pkg::sbst_state_t state_r
);
   sbst_pkg::sbst_state_t state_nxt;

   always_comb
   begin
      state_nxt = state_r;
      if (force_tlr)
         state_nxt = sbst_pkg::ST_TLR;
      else if (step)
      begin
         unique case (state_r) // RULE18
            sbst_pkg::ST_TLR: state_nxt = tms ? sbst_pkg::ST_TLR : sbst_pkg::ST_RTI;
            sbst_pkg::ST_RTI: state_nxt = tms ? sbst_pkg::ST_SELDR : sbst_pkg::ST_RTI;
            sbst_pkg::ST_SELDR: state_nxt = tms ? sbst_pkg::ST_SELIR : sbst_pkg::ST_CAPDR;
            sbst_pkg::ST_CAPDR: state_nxt = tms ? sbst_pkg::ST_EX1DR : sbst_pkg::ST_SHDR;
            sbst_pkg::ST_SHDR: state_nxt = tms ? sbst_pkg::ST_EX1DR : sbst_pkg::ST_SHDR;
            sbst_pkg::ST_EX1DR: state_nxt = tms ? sbst_pkg::ST_UPDR : sbst_pkg::ST_PDR;
            sbst_pkg::ST_PDR: state_nxt = tms ? sbst_pkg::ST_EX2DR : sbst_pkg::ST_PDR;
            sbst_pkg::ST_EX2DR: state_nxt = tms ? sbst_pkg::ST_UPDR : sbst_pkg::ST_SHDR;
            sbst_pkg::ST_UPDR: state_nxt = tms ? sbst_pkg::ST_SELDR : sbst_pkg::ST_RTI;
            sbst_pkg::ST_SELIR: state_nxt = tms ? sbst_pkg::ST_TLR : sbst_pkg::ST_CAPIR;
            sbst_pkg::ST_CAPIR: state_nxt = tms ? sbst_pkg::ST_EX1IR : sbst_pkg::ST_SHIR;
            sbst_pkg::ST_SHIR: state_nxt = tms ? sbst_pkg::ST_EX1IR : sbst_pkg::ST_SHIR;
            sbst_pkg::ST_EX1IR: state_nxt = tms ? sbst_pkg::ST_UPIR : sbst_pkg::ST_PIR;
            sbst_pkg::ST_PIR: state_nxt = tms ? sbst_pkg::ST_EX2IR : sbst_pkg::ST_PIR;
            sbst_pkg::ST_EX2IR: state_nxt = tms ? sbst_pkg::ST_UPIR : sbst_pkg::ST_SHIR;
            sbst_pkg::ST_UPIR: state_nxt = tms ? sbst_pkg::ST_SELDR : sbst_pkg::ST_RTI;
            default: state_nxt = sbst_pkg::ST_TLR;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
         state_r <= sbst_pkg::ST_TLR;
      else
         state_r <= state_nxt;
   end

   tlr_exit_a: assert property (@(posedge mclk) disable iff (srst) // RULE18
      step && !force_tlr && !tms && state_r == sbst_pkg::ST_TLR |=> state_r == sbst_pkg::ST_RTI)
      else $error("test-logic-reset did not move to idle");
endmodule // sbst_tap_fsm

// >>> rtl/sbst_tap.sv
/*
 Boundary-scan test port of a burst SRAM with an AXI4-Lite status slave.
 Assumes tck, tms, tdi and the pin ring are asynchronous and slow against mclk.
*/
// Contract
// [RULE1] Code 000 captures ring, shifts boundary chain
// [RULE2] Code 001 captures and shifts 32-bit ID
// [RULE3] Code 010 captures ring, outputs high impedance
// [RULE4] Code 100 captures ring, memory unaffected
// [RULE5] Code 111 selects one-bit bypass register
// [RULE6] Controller never loads codes 011, 101, 110; code loads them at Update-IR and they select bypass
// [RULE7] ID: revision, part, maker, constant one
// [RULE8] Lengths: IR 3, bypass 1, ID 32, boundary 109
// [RULE9] Serial output changes after test clock fall
// [RULE10] Mode and data sampled at clock rise
// [RULE11] System drives DLL disable pin high
// [RULE12] System waits 1024 cycles for DLL lock
// [RULE13] System clock not below 120 MHz
// [RULE14] System gives 1024 stable cycles to relock
// [RULE15] Cell 108 gates outputs under external test
// [RULE16] ID instruction after reset and Test-Logic-Reset
// [RULE17] Boundary MSB at input, LSB at output
// [RULE18] Standard sixteen-state controller on test clock
// [RULE19] Instruction acts at Update-IR; shift one bit
`timescale 1ns/1ps
module sbst_tap #(
   parameter int BSR_LEN = sbst_pkg::BSR_LEN,
   parameter logic [2:0] ID_REV = 3'h0,
   parameter logic [16:0] ID_PART = 17'h0a5a5, // Arbitrary value
   parameter logic [10:0] ID_MAKER = 11'h05a // Arbitrary value
) (
   input wire logic mclk,
   input wire logic srst,
   input wire sbst_pkg::sbst_tap_in_t tap_pins,
   input wire logic [BSR_LEN-2:0] ring_in,
   output logic tdo_r,
   output logic tdo_oe_r,
   output logic q_oe_r,
   output logic ring_sel_r,
   output logic [BSR_LEN-2:0] ring_drive_r,
   input wire logic [sbst_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [sbst_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam logic [31:0] ID_WORD = {ID_REV, ID_PART, ID_MAKER, 1'b1}; // RULE7

   if (BSR_LEN != sbst_pkg::BSR_LEN)
   begin : g_chk
      $error("sbst_tap: boundary length must be 109"); // RULE8
   end

   sbst_pkg::sbst_tap_in_t pins_s;
   logic [BSR_LEN-2:0] ring_s;
   sbst_pkg::sbst_state_t state_r;
   logic tck_d_r, tck_rise, tck_fall;
   logic [2:0] ir_r, ir_nxt, ir_sh_r, ir_sh_nxt;
   logic [BSR_LEN-1:0] bsr_r, bsr_nxt, upd_r, upd_nxt;
   logic [31:0] id_r, id_nxt;
   logic byp_r, byp_nxt, tdo_nxt, tdo_oe_nxt;
   logic q_oe_nxt, ring_sel_nxt, sel_bsr, sel_id, dr_lsb;
   logic [31:0] ctrl_r, ctrl_nxt, rdata_nxt;
   logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
   logic [sbst_pkg::AXI_AW-1:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic wstrb0_r, wstrb0_nxt;
   logic awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
   logic [1:0] bresp_nxt, rresp_nxt;

   // Pins cross into mclk before any logic sees them
   sbst_sync #(.W(3)) u_pin_sync (
      .mclk(mclk),
      .srst(srst),
      .d(tap_pins),
      .q_r(pins_s)
   );
   sbst_sync #(.W(BSR_LEN - 1)) u_ring_sync (
      .mclk(mclk),
      .srst(srst),
      .d(ring_in),
      .q_r(ring_s)
   );

   assign tck_rise = pins_s.tck & ~tck_d_r;
   assign tck_fall = ~pins_s.tck & tck_d_r;

   sbst_tap_fsm u_fsm (
      .mclk(mclk),
      .srst(srst),
      .step(tck_rise),
      .tms(pins_s.tms), // RULE10
      .force_tlr(ctrl_r[sbst_pkg::CTRL_TAP_RST_BIT]),
      .state_r(state_r)
   );

   function automatic logic addr_known(input logic [sbst_pkg::AXI_AW-1:0] a);
      addr_known = (a == sbst_pkg::OFS_CTRL) || (a == sbst_pkg::OFS_STATUS) ||
                   (a == sbst_pkg::OFS_IDWORD);
   endfunction

   // Reserved codes fall back to the bypass path
   assign sel_bsr = (ir_r == sbst_pkg::IR_EXTEST) || (ir_r == sbst_pkg::IR_SAMPLEZ) ||
                    (ir_r == sbst_pkg::IR_SAMPLE); // RULE1 RULE3 RULE4
   assign sel_id = (ir_r == sbst_pkg::IR_IDCODE); // RULE2
   assign dr_lsb = sel_bsr ? bsr_r[0] : (sel_id ? id_r[0] : byp_r); // RULE5 RULE17

   always_comb
   begin
      ir_nxt = ir_r;
      ir_sh_nxt = ir_sh_r;
      bsr_nxt = bsr_r;
      upd_nxt = upd_r;
      id_nxt = id_r;
      byp_nxt = byp_r;
      tdo_nxt = tdo_r;
      tdo_oe_nxt = tdo_oe_r;
      if (tck_rise)
      begin
         if (state_r == sbst_pkg::ST_CAPDR)
         begin
            if (sel_bsr)
               bsr_nxt = {upd_r[BSR_LEN-1], ring_s}; // RULE1 RULE3 RULE4
            if (sel_id)
               id_nxt = ID_WORD; // RULE2
            byp_nxt = 1'b0;
         end
         if (state_r == sbst_pkg::ST_SHDR)
         begin
            if (sel_bsr)
               bsr_nxt = {pins_s.tdi, bsr_r[BSR_LEN-1:1]}; // RULE17 RULE19
            if (sel_id)
               id_nxt = {pins_s.tdi, id_r[31:1]}; // RULE19
            byp_nxt = pins_s.tdi; // RULE5
         end
         if (state_r == sbst_pkg::ST_CAPIR)
            ir_sh_nxt = sbst_pkg::IR_CAPT_PAT;
         if (state_r == sbst_pkg::ST_SHIR)
            ir_sh_nxt = {pins_s.tdi, ir_sh_r[2:1]}; // RULE10
      end
      if (tck_fall)
      begin
         if (state_r == sbst_pkg::ST_UPDR && sel_bsr)
            upd_nxt = bsr_r;
         if (state_r == sbst_pkg::ST_UPIR)
            ir_nxt = ir_sh_r; // RULE19
         tdo_oe_nxt = (state_r == sbst_pkg::ST_SHDR) || (state_r == sbst_pkg::ST_SHIR);
         if (state_r == sbst_pkg::ST_SHIR)
            tdo_nxt = ir_sh_r[0]; // RULE9
         else if (state_r == sbst_pkg::ST_SHDR)
            tdo_nxt = dr_lsb; // RULE9
         else
            tdo_nxt = 1'b0;
      end
      if (state_r == sbst_pkg::ST_TLR)
      begin
         ir_nxt = sbst_pkg::IR_IDCODE; // RULE16
         upd_nxt[BSR_LEN-1] = 1'b0;
      end
      q_oe_nxt = (ir_r != sbst_pkg::IR_SAMPLEZ) && // RULE3
                 !((ir_r == sbst_pkg::IR_EXTEST) && !upd_r[BSR_LEN-1]); // RULE15
      ring_sel_nxt = (ir_r == sbst_pkg::IR_EXTEST);
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         tck_d_r <= 1'b0;
         ir_r <= sbst_pkg::IR_IDCODE; // RULE16
         ir_sh_r <= sbst_pkg::IR_CAPT_PAT;
         bsr_r <= '0;
         upd_r <= '0;
         id_r <= '0;
         byp_r <= 1'b0;
         tdo_r <= 1'b0;
         tdo_oe_r <= 1'b0;
         q_oe_r <= 1'b1;
         ring_sel_r <= 1'b0;
         ring_drive_r <= '0;
      end
      else
      begin
         tck_d_r <= pins_s.tck;
         ir_r <= ir_nxt;
         ir_sh_r <= ir_sh_nxt;
         bsr_r <= bsr_nxt;
         upd_r <= upd_nxt;
         id_r <= id_nxt;
         byp_r <= byp_nxt;
         tdo_r <= tdo_nxt;
         tdo_oe_r <= tdo_oe_nxt;
         q_oe_r <= q_oe_nxt;
         ring_sel_r <= ring_sel_nxt;
         ring_drive_r <= upd_r[BSR_LEN-2:0];
      end
   end

   // AXI4-Lite slave: address and data taken in either order, write a cycle later
   always_comb
   begin
      aw_got_nxt = aw_got_r | (s_axi_awvalid & s_axi_awready);
      w_got_nxt = w_got_r | (s_axi_wvalid & s_axi_wready);
      awaddr_nxt = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awaddr_r;
      wdata_nxt = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wdata_r;
      wstrb0_nxt = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb[0] : wstrb0_r;
      ctrl_nxt = ctrl_r;
      bvalid_nxt = s_axi_bvalid & ~s_axi_bready;
      bresp_nxt = s_axi_bresp;
      if (aw_got_r && w_got_r)
      begin
         aw_got_nxt = 1'b0;
         w_got_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = addr_known(awaddr_r) ? sbst_pkg::RESP_OKAY : sbst_pkg::RESP_SLVERR;
         if (awaddr_r == sbst_pkg::OFS_CTRL && wstrb0_r)
            ctrl_nxt = {24'h00_0000, wdata_r[7:0]} & 32'h0000_0001;
      end
      awready_nxt = ~aw_got_nxt & ~bvalid_nxt;
      wready_nxt = ~w_got_nxt & ~bvalid_nxt;
      rvalid_nxt = s_axi_rvalid & ~s_axi_rready;
      rdata_nxt = s_axi_rdata;
      rresp_nxt = s_axi_rresp;
      if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt = addr_known(s_axi_araddr) ? sbst_pkg::RESP_OKAY : sbst_pkg::RESP_SLVERR;
         unique case (s_axi_araddr)
            sbst_pkg::OFS_CTRL: rdata_nxt = ctrl_r;
            sbst_pkg::OFS_STATUS: rdata_nxt = {state_r, 10'h000, tdo_oe_r, ring_sel_r,
                                               q_oe_r, ir_r};
            sbst_pkg::OFS_IDWORD: rdata_nxt = ID_WORD;
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
      arready_nxt = ~rvalid_nxt;
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         ctrl_r <= sbst_pkg::CTRL_RESET;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb0_r <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= sbst_pkg::RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= sbst_pkg::RESP_OKAY;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb0_r <= wstrb0_nxt;
         s_axi_awready <= awready_nxt;
         s_axi_wready <= wready_nxt;
         s_axi_bvalid <= bvalid_nxt;
         s_axi_bresp <= bresp_nxt;
         s_axi_arready <= arready_nxt;
         s_axi_rvalid <= rvalid_nxt;
         s_axi_rdata <= rdata_nxt;
         s_axi_rresp <= rresp_nxt;
      end
   end

   default clocking dflt_cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   sequence ir_load_s;
      tck_fall && state_r == sbst_pkg::ST_UPIR;
   endsequence

   ir_reset_a: assert property (state_r == sbst_pkg::ST_TLR |=> ir_r == sbst_pkg::IR_IDCODE) // RULE16
      else $error("instruction not reset to identification");
   ir_update_a: assert property (ir_load_s |=> ir_r == $past(ir_sh_r)) // RULE19
      else $error("instruction not loaded at update");
   ir_hold_a: assert property (!(tck_fall && state_r == sbst_pkg::ST_UPIR) && // RULE19
      state_r != sbst_pkg::ST_TLR |=> $stable(ir_r))
      else $error("instruction changed outside update");
   id_capture_a: assert property (tck_rise && sel_id && state_r == sbst_pkg::ST_CAPDR
      |=> id_r == ID_WORD && id_r[0]) // RULE2
      else $error("identification word not captured");
   bsr_shift_a: assert property (tck_rise && sel_bsr && state_r == sbst_pkg::ST_SHDR
      |=> bsr_r[BSR_LEN-1] == $past(pins_s.tdi) && bsr_r[0] == $past(bsr_r[1])) // RULE17
      else $error("boundary chain shifted wrongly");
   ring_capture_a: assert property (tck_rise && sel_bsr && state_r == sbst_pkg::ST_CAPDR
      |=> bsr_r[BSR_LEN-2:0] == $past(ring_s)) // RULE1
      else $error("pin ring not captured");
   bypass_shift_a: assert property (tck_rise && ir_r == sbst_pkg::IR_BYPASS &&
      state_r == sbst_pkg::ST_SHDR |=> byp_r == $past(pins_s.tdi)) // RULE5
      else $error("bypass bit not shifted");
   tdo_fall_a: assert property ($changed(tdo_r) |-> $past(tck_fall)) // RULE9
      else $error("serial output moved without a falling edge");
   samplez_hiz_a: assert property (ir_r == sbst_pkg::IR_SAMPLEZ |=> !q_oe_r) // RULE3
      else $error("outputs driven during high-impedance sample");
   extest_gate_a: assert property (ir_r == sbst_pkg::IR_EXTEST
      |=> q_oe_r == $past(upd_r[BSR_LEN-1])) // RULE15
      else $error("cell 108 not gating outputs");
endmodule // sbst_tap

// >>> verif/sbst_jtag_ctl.sv
/*
 Model of the external boundary-scan controller and of the memory's clock source.
 Assumes the port shifts LSB first and moves tdo only after a test clock fall.
*/
`timescale 1ns/1ps
module sbst_jtag_ctl (
   output sbst_pkg::sbst_tap_in_t pins,
   input wire logic tdo
);
   logic kclk = 1'b0;
   logic dll_disable_pin = 1'b0;
   int dll_cnt = 0;

   initial
   begin
      pins = 3'h0;
   end

   // Memory clock at 125 MHz, above the lowest rate the DLL follows
   always #4 kclk = ~kclk;

   // Lock count restarts whenever the DLL disable pin is low
   always @(posedge kclk) dll_cnt = dll_disable_pin ? dll_cnt + 1 : 0;

   // Pin starts at a defined low level, then goes high; wait 1024 stable cycles
   task automatic dll_start();
      dll_disable_pin = 1'b1;
      wait (dll_cnt >= 1024);
   endtask

   // One test clock of 200 ns: low 125, high 75; tck rests low between frames
   task automatic step(input logic tms, input logic tdi, output logic tdo_s);
      pins.tms = tms;
      pins.tdi = tdi;
      #124;
      tdo_s = tdo;
      #1;
      pins.tck = 1'b1;
      #75;
      pins.tck = 1'b0;
   endtask

   // Frames start 7 ns off the system clock edge
   task automatic tlr();
      logic t;
      #7;
      for (int i = 0; i < 5; i++) step(1'b1, 1'b0, t);
      step(1'b0, 1'b0, t);
   endtask

   // From idle: capture, shift three bits, update, back to idle
   task automatic ir(input logic [2:0] code, output logic [2:0] cap);
      logic t;
      #7;
      step(1'b1, 1'b0, t);
      step(1'b1, 1'b0, t);
      step(1'b0, 1'b0, t);
      step(1'b0, 1'b0, t);
      // Only defined codes are ever loaded
      for (int i = 0; i < 3; i++) step(i == 2, code[i], cap[i]);
      step(1'b1, 1'b0, t);
      step(1'b0, 1'b0, t);
   endtask

   task automatic dr(input logic [127:0] din, output logic [127:0] dout);
      logic t;
      #7;
      step(1'b1, 1'b0, t);
      step(1'b0, 1'b0, t);
      step(1'b0, 1'b0, t);
      for (int i = 0; i < 128; i++) step(i == 127, din[i], dout[i]);
      step(1'b1, 1'b0, t);
      step(1'b0, 1'b0, t);
   endtask
endmodule // sbst_jtag_ctl

// >>> verif/tb_top.sv
/*
 Self-checking bench of the boundary-scan port: AXI4-Lite status and scans.
 Assumes the jtag controller model drives the pins at a 200 ns test clock.
*/
`timescale 1ns/1ps
module tb_top;
   localparam logic [2:0] ID_REV = 3'h5; // Arbitrary value
   localparam logic [16:0] ID_PART = 17'h1c3e5; // Arbitrary value
   localparam logic [10:0] ID_MAKER = 11'h2b1; // Arbitrary value
   localparam logic [31:0] ID_WORD = {ID_REV, ID_PART, ID_MAKER, 1'b1};
   localparam logic [2:0] CODES [7] = '{3'h4, 3'h0, 3'h2, 3'h7, 3'h1, 3'h4, 3'h7};
   localparam logic [1:0] OK = sbst_pkg::RESP_OKAY;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   sbst_pkg::sbst_tap_in_t pins;
   logic [107:0] ring_in = 108'h0;
   logic [107:0] ring_drive_r;
   logic tdo_r, tdo_oe_r, q_oe_r, ring_sel_r, tdo_h, c108 = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, xs_r = 32'hfb97;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   int error_cnt = 0;
   int compares = 0;

   always #12.5 mclk = ~mclk;

   sbst_tap #(.ID_REV(ID_REV), .ID_PART(ID_PART), .ID_MAKER(ID_MAKER)) u_sbst_tap (
      .mclk(mclk), .srst(srst), .tap_pins(pins), .ring_in(ring_in), .tdo_r(tdo_r),
      .tdo_oe_r(tdo_oe_r), .q_oe_r(q_oe_r), .ring_sel_r(ring_sel_r),
      .ring_drive_r(ring_drive_r), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   sbst_jtag_ctl u_sbst_jtag_ctl (.pins(pins), .tdo(tdo_r));

   function logic [31:0] rnd();
      xs_r = xs_r ^ (xs_r << 13);
      xs_r = xs_r ^ (xs_r >> 17);
      xs_r = xs_r ^ (xs_r << 5);
      return xs_r;
   endfunction

   function automatic logic is_bsr(input logic [2:0] c);
      return c == 3'h0 || c == 3'h2 || c == 3'h4;
   endfunction

   function automatic logic exp_q(input logic [2:0] c);
      return (c == 3'h2) ? 1'b0 : ((c == 3'h0) ? c108 : 1'b1);
   endfunction

   function automatic logic [31:0] st_word(input logic [2:0] c, input logic [15:0] st);
      return {st, 10'h0, 1'b0, c == 3'h0, exp_q(c), c};
   endfunction

   // Captured word leaves first, then the bits fed in come back after len shifts
   function automatic logic [127:0] exp_dr(input logic [2:0] c, input logic [127:0] din);
      logic [127:0] cap;
      int len;
      cap = 128'h0;
      len = 1;
      if (is_bsr(c))
      begin
         cap = {19'h0, c108, ring_in};
         len = 109;
      end
      else if (c == 3'h1)
      begin
         cap = {96'h0, ID_WORD};
         len = 32;
      end
      return (cap & ((128'h1 << len) - 128'h1)) | (din << len);
   endfunction

   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 50);
      r = bresp;
      bready <= 1'b0;
      if (bvalid !== 1'b1) error_cnt++;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 50);
      rready <= 1'b0;
      if (rvalid !== 1'b1) error_cnt++;
      check(rdata, e);
      check(rresp, er);
   endtask

   // Serial output must hold through the whole high phase of the test clock
   always @(posedge pins.tck) tdo_h = tdo_r;
   always @(negedge pins.tck) if (!srst) check(tdo_r, tdo_h);

   initial
   begin
      repeat (40000) @(posedge mclk);
      error_cnt++;
      conclude();
   end

   initial
   begin
      logic [127:0] din, dout;
      logic [2:0] cap, code;
      logic [1:0] r;
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      u_sbst_jtag_ctl.dll_start();
      rd_chk(sbst_pkg::OFS_STATUS, st_word(3'h1, 16'h0001), OK);
      rd_chk(sbst_pkg::OFS_IDWORD, ID_WORD, OK);
      rd_chk(sbst_pkg::OFS_CTRL, 32'h0, OK);
      rd_chk(8'h0c, 32'h0, sbst_pkg::RESP_SLVERR);
      axi_wr(8'h10, 32'h1, r);
      check(r, sbst_pkg::RESP_SLVERR);
      u_sbst_jtag_ctl.tlr();
      din = {rnd(), rnd(), rnd(), rnd()};
      u_sbst_jtag_ctl.dr(din, dout);
      check(dout, exp_dr(3'h1, din));
      foreach (CODES[k])
      begin
         code = CODES[k];
         din = {rnd(), rnd(), rnd(), rnd()};
         ring_in <= din[107:0];
         u_sbst_jtag_ctl.ir(code, cap);
         check(cap, 3'h1);
         rd_chk(sbst_pkg::OFS_STATUS, st_word(code, 16'h0002), OK);
         check(q_oe_r, exp_q(code));
         check(ring_sel_r, code == 3'h0);
         din = {rnd(), rnd(), rnd(), rnd()};
         din[127] = (code == 3'h4);
         u_sbst_jtag_ctl.dr(din, dout);
         check(dout, exp_dr(code, din));
         if (is_bsr(code))
         begin
            c108 = din[127];
            check(ring_drive_r, din[126:19]);
         end
         check(q_oe_r, exp_q(code));
      end
      axi_wr(sbst_pkg::OFS_CTRL, 32'h1, r);
      check(r, OK);
      rd_chk(sbst_pkg::OFS_CTRL, 32'h1, OK);
      c108 = 1'b0;
      rd_chk(sbst_pkg::OFS_STATUS, st_word(3'h1, 16'h0001), OK);
      axi_wr(sbst_pkg::OFS_CTRL, 32'h0, r);
      check(r, OK);
      wstrb <= 4'he;
      axi_wr(sbst_pkg::OFS_CTRL, 32'h1, r);
      check(r, OK);
      rd_chk(sbst_pkg::OFS_CTRL, 32'h0, OK);
      wstrb <= 4'hf;
      u_sbst_jtag_ctl.tlr();
      u_sbst_jtag_ctl.ir(3'h0, cap);
      rd_chk(sbst_pkg::OFS_STATUS, st_word(3'h0, 16'h0002), OK);
      u_sbst_jtag_ctl.tlr();
      rd_chk(sbst_pkg::OFS_STATUS, st_word(3'h1, 16'h0002), OK);
      conclude();
   end
endmodule // tb_top
